// ===== logic/sysreg_pkg.sv
// Package with offsets, reset values and field positions of the system register bank.
package sysreg_pkg;
	localparam int          ADDR_W          = 24;
	localparam logic [23:0] OFF_CHIP_ID     = 24'h10_2400;
	localparam logic [23:0] OFF_FRAME_CNT   = 24'h10_2404;
	localparam logic [23:0] OFF_CYCLE_CNT   = 24'h10_2408;
	localparam logic [23:0] OFF_MAIN_HZ     = 24'h10_240C;
	localparam logic [23:0] OFF_COPROC_RST  = 24'h10_241C;
	localparam logic [31:0] MAIN_HZ_RESET   = 32'h02DC_6C00;
	localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
	localparam int          COPROC_RST_BIT  = 0;
	localparam int          CHIP_ID_W       = 8;
	// Identity value is arbitrary.
	localparam logic [7:0]  CHIP_ID_DEFAULT = 8'h5A;
	localparam int          SYNC_STAGES     = 3;
endpackage

// ===== logic/count_if.sv
// Interface joining the bank to its counter instances, the free-running cycle counter and the frame counter.
`timescale 1ns/1ps
interface count_if;
	logic        step;
	logic [31:0] value;
	modport counter (input step, output value);
	modport user    (output step, input value);
endinterface

// ===== logic/wrap_counter.sv
// Thirty-two bit counter that steps when asked and wraps to zero.
`timescale 1ns/1ps
module wrap_counter
	import sysreg_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	count_if.counter  cnt
);
	logic [31:0] countQ;
	logic [31:0] countD;

	// All-ones plus one truncates to zero, so wrap needs no special case.
	always_comb begin
		countD = cnt.step ? countQ + 32'h0000_0001 : countQ;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			countQ <= WORD_ZERO;
		end else begin
			countQ <= countD;
		end
	end

	assign cnt.value = countQ;

	a_count_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		cnt.step && countQ == 32'hFFFF_FFFF |=> countQ == WORD_ZERO)
		else $error("Counter did not wrap to zero.");
endmodule

// ===== logic/system_control_status_regs.sv
// System control and status register bank: reset control, clock value, counters, identity.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Writing bit 0 as one puts the coprocessor engines in reset and holds.
// - Writing bit 0 as zero releases the coprocessor engines from reset.
// - Bit 0 reads one while engines are held in reset, else zero.
// - Bits 1 to 31 of reset control read zero; writes ignored.
// - Reset control reads zero after device reset; engines run.
// - Clock frequency register resets to 48 MHz in hertz, host read/write.
// - Cycle counter is zero after device reset.
// - Cycle counter steps every clock; host can only read it.
// - Cycle counter wraps from all ones to zero and continues.
// - Identity register is a read-only eight-bit build code; upper bits zero.
module system_control_status_regs
	import sysreg_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = CHIP_ID_DEFAULT
)
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [31:0]            regRdata,
	input  wire logic              frameDone,
	output logic                   coprocReset
);
	logic [SYNC_STAGES-1:0] frameSyncQ;
	logic [SYNC_STAGES-1:0] frameSyncD;
	logic                   frameLevelQ;
	logic                   frameLevelD;
	logic                   frameStep;
	logic                   coprocRstQ;
	logic                   coprocRstD;
	logic [31:0]            mainHzQ;
	logic [31:0]            mainHzD;
	logic [31:0]            rdataQ;
	logic [31:0]            rdataD;

	// One carrier per counter; the bank drives the step and only reads the value back.
	count_if cycleIf ();
	count_if frameIf ();

	// The frame pulse comes from the display timing, possibly another domain.
	// Three stages; a change counts once stages two and three agree.
	always_comb begin
		frameSyncD  = {frameSyncQ[SYNC_STAGES-2:0], frameDone};
		frameLevelD = frameLevelQ;
		if (frameSyncQ[1] == frameSyncQ[2]) begin
			frameLevelD = frameSyncQ[2];
		end
		frameStep = frameLevelD & ~frameLevelQ;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frameSyncQ  <= '0;
			frameLevelQ <= 1'b0;
		end else begin
			frameSyncQ  <= frameSyncD;
			frameLevelQ <= frameLevelD;
		end
	end

	// Cycle counter steps on every clock and wraps freely.
	assign cycleIf.step = 1'b1;
	assign frameIf.step = frameStep;

	// Both counters share one module, so wrap behaviour cannot drift between them.
	wrap_counter u_cycle (
		.clk     (clk),
		.reset_n (reset_n),
		.cnt     (cycleIf.counter)
	);

	wrap_counter u_frame (
		.clk     (clk),
		.reset_n (reset_n),
		.cnt     (frameIf.counter)
	);

	// Writable state. Counters and identity have no write path at all.
	always_comb begin
		coprocRstD = coprocRstQ;
		mainHzD    = mainHzQ;
		if (regWrite) begin
			case (regAddr)
				OFF_COPROC_RST: begin
					coprocRstD = regWdata[COPROC_RST_BIT];
				end
				OFF_MAIN_HZ: begin
					mainHzD = regWdata;
				end
				default: begin
					coprocRstD = coprocRstQ;
				end
			endcase
		end
	end

	// Read data is registered and valid only in the cycle after the strobe.
	always_comb begin
		rdataD = WORD_ZERO;
		if (regRead) begin
			case (regAddr)
				OFF_CHIP_ID:    rdataD = {24'h00_0000, CHIP_ID};
				OFF_FRAME_CNT:  rdataD = frameIf.value;
				OFF_CYCLE_CNT:  rdataD = cycleIf.value;
				OFF_MAIN_HZ:    rdataD = mainHzQ;
				OFF_COPROC_RST: rdataD = {31'h0000_0000, coprocRstQ};
				default:        rdataD = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			coprocRstQ <= 1'b0;
			mainHzQ    <= MAIN_HZ_RESET;
			rdataQ     <= WORD_ZERO;
		end else begin
			coprocRstQ <= coprocRstD;
			mainHzQ    <= mainHzD;
			rdataQ     <= rdataD;
		end
	end

	// The engines see the stored bit directly, so readback matches them as they stood at the strobe edge.
	assign coprocReset = coprocRstQ;
	assign regRdata    = rdataQ;

	// Checks on the reset control bit, the clock value, the counters and the identity.
	// Every read check looks one cycle after the strobe, where the registered data stand.
	// Checks that start at the release of reset carry no disable, so they see the
	// reset values at the first edge after release.
	// A write of one must reach the engines at the next edge.
	a_rst_set: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_COPROC_RST && regWdata[0] |=> coprocReset)
		else $error("Coprocessor reset not asserted after write of one.");

	// A write of zero must free the engines at the next edge.
	a_rst_clear: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_COPROC_RST && !regWdata[0] |=> !coprocReset)
		else $error("Coprocessor reset not released after write of zero.");

	// Readback reflects the engine state at the strobe edge.
	a_rst_readback: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_COPROC_RST |=> regRdata == {31'h0, $past(coprocReset)})
		else $error("Reset control readback does not match engine state.");

	// Reserved bits never show write data.
	a_rst_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_COPROC_RST |=> regRdata[31:1] == 31'h0)
		else $error("Reserved reset control bits read nonzero.");

	// Without a write the engines stay in whatever state software left them.
	a_rst_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(regWrite && regAddr == OFF_COPROC_RST) |=> coprocReset == $past(coprocReset))
		else $error("Coprocessor reset changed without a write.");

	// A written clock value reads back unchanged on the next access.
	a_hz_write: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_MAIN_HZ ##1 regRead && regAddr == OFF_MAIN_HZ
		|=> regRdata == $past(regWdata, 2))
		else $error("Clock frequency readback differs from written value.");

	// Two reads in a row of the cycle counter differ by exactly one.
	a_cycle_step: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CYCLE_CNT ##1 regRead && regAddr == OFF_CYCLE_CNT
		|=> regRdata == $past(regRdata) + 32'h0000_0001)
		else $error("Cycle counter did not advance by one per clock.");

	// Overflow takes many seconds of clock, so only formal tools reach this one.
	a_cycle_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		cycleIf.value == 32'hFFFF_FFFF |=> cycleIf.value == WORD_ZERO)
		else $error("Cycle counter did not wrap.");

	// The identity reads as the build code parameter, zero extended.
	a_id_fixed: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CHIP_ID |=> regRdata == {24'h0, CHIP_ID})
		else $error("Identity register read wrong value.");

	// Each accepted frame edge adds exactly one to the frame count.
	a_frame_step: assert property (@(posedge clk) disable iff (!reset_n)
		frameStep |=> frameIf.value == $past(frameIf.value) + 32'h0000_0001)
		else $error("Frame counter did not step on frame end.");

	// At release the engines run and the read data are clear.
	// This check has no disable so that it sees the first edge after release.
	a_reset_values: assert property (@(posedge clk)
		$rose(reset_n) |-> !coprocReset && regRdata == WORD_ZERO)
		else $error("Control or read data not cleared by reset.");

	// The clock value comes back to its default at every reset.
	// Software that changed the clock must write it again afterwards.
	a_hz_reset: assert property (@(posedge clk)
		$rose(reset_n) |-> mainHzQ == MAIN_HZ_RESET)
		else $error("Clock frequency value not restored by reset.");

	// The cycle count starts from zero at release.
	// Software measuring time since reset relies on this.
	a_cycle_reset: assert property (@(posedge clk)
		$rose(reset_n) |-> cycleIf.value == WORD_ZERO)
		else $error("Cycle counter not zero after reset.");

	// The frame count starts from zero at release.
	// A frame edge during reset is dropped, not remembered.
	a_frame_reset: assert property (@(posedge clk)
		$rose(reset_n) |-> frameIf.value == WORD_ZERO)
		else $error("Frame counter not zero after reset.");

	// The cycle counter advances on every edge with no gaps.
	// A stalled counter would break software timeouts built on it.
	a_cycle_every: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> cycleIf.value == $past(cycleIf.value) + 32'h0000_0001)
		else $error("Cycle counter missed a clock.");

	// A cycle counter read returns the count at the strobe edge.
	// The answer is one cycle old by the time software sees it.
	a_cycle_read: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CYCLE_CNT |=> regRdata == $past(cycleIf.value))
		else $error("Cycle counter read wrong value.");

	// A frame counter read returns the count at the strobe edge.
	// A frame ending in the same cycle shows only on the next read.
	a_frame_read: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_FRAME_CNT |=> regRdata == $past(frameIf.value))
		else $error("Frame counter read wrong value.");

	// A clock value read returns the stored word.
	// The stored word is trusted as given; no range is enforced.
	a_hz_read: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_MAIN_HZ |=> regRdata == $past(mainHzQ))
		else $error("Clock frequency read wrong value.");

	// A clock value write stores the full word.
	// There are no byte enables, so partial writes are not possible.
	a_hz_store: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_MAIN_HZ |=> mainHzQ == $past(regWdata))
		else $error("Clock frequency write not stored.");

	// Without a write the clock value holds.
	// Writes to other places must not disturb it.
	a_hz_keep: assert property (@(posedge clk) disable iff (!reset_n)
		!(regWrite && regAddr == OFF_MAIN_HZ) |=> mainHzQ == $past(mainHzQ))
		else $error("Clock frequency changed without a write.");

	// Only the low byte of the identity word carries the code.
	// Upper bits read zero so wide compares by software still work.
	a_id_upper: assert property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CHIP_ID |=> regRdata[31:CHIP_ID_W] == 24'h00_0000)
		else $error("Identity upper bits read nonzero.");

	// Without an accepted frame edge the frame count holds.
	// Noise on the frame pin must not add counts.
	a_frame_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!frameStep |=> frameIf.value == $past(frameIf.value))
		else $error("Frame counter changed without a frame.");

	// One frame edge gives one step, however long the pin stays high.
	// The stored level must fall before another step can come.
	a_frame_single: assert property (@(posedge clk) disable iff (!reset_n)
		frameStep |=> !frameStep)
		else $error("Frame counter stepped twice for one frame.");

	// A step needs the second and third stages to agree on high.
	// This keeps a metastable first stage from counting.
	a_frame_agree: assert property (@(posedge clk) disable iff (!reset_n)
		frameStep |-> frameSyncQ[1] && frameSyncQ[2])
		else $error("Frame step taken without agreeing stages.");

	// While the two stages disagree the stored level may not move.
	// Short glitches shorter than two clocks are filtered here.
	a_level_gate: assert property (@(posedge clk) disable iff (!reset_n)
		frameSyncQ[1] != frameSyncQ[2] |=> frameLevelQ == $past(frameLevelQ))
		else $error("Frame level moved while stages disagreed.");

	// The frame count wraps to zero after its all-ones value.
	// At display rates this takes far longer than any simulation.
	a_frame_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		frameStep && frameIf.value == 32'hFFFF_FFFF |=> frameIf.value == WORD_ZERO)
		else $error("Frame counter did not wrap.");

	// A write to the cycle counter is ignored; counting just goes on.
	// Software cannot rewind time by writing this place.
	a_ro_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_CYCLE_CNT |=> cycleIf.value == $past(cycleIf.value) + 1)
		else $error("Cycle counter disturbed by a write.");

	// A write to the frame counter is ignored.
	// Only the frame pin may move this count.
	a_ro_frame: assert property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_FRAME_CNT && !frameStep
		|=> frameIf.value == $past(frameIf.value))
		else $error("Frame counter disturbed by a write.");

	// Scenarios that the bench is expected to reach.

	c_rst_cycle: cover property (@(posedge clk) disable iff (!reset_n)
		coprocReset ##[1:20] !coprocReset);
	c_hz_write: cover property (@(posedge clk) disable iff (!reset_n)
		regWrite && regAddr == OFF_MAIN_HZ);
	c_frame: cover property (@(posedge clk) disable iff (!reset_n) frameStep);
	c_cycle_read: cover property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CYCLE_CNT);
	c_id_read: cover property (@(posedge clk) disable iff (!reset_n)
		regRead && regAddr == OFF_CHIP_ID);
endmodule

// ===== verif/tb_system_control_status_regs.sv
// Self-checking bench for the system control and status register bank.
`timescale 1ns/1ps
module tb_system_control_status_regs
	import sysreg_pkg::*;
();
	// Identity value is arbitrary, chosen to differ from the package default.
	localparam logic [7:0] TEST_ID = 8'hA5;
	// Kind 0 is an exact value, 1 only records, 2 expects the last value plus data.
	typedef struct packed {logic [31:0] data; logic rst; logic [1:0] kind;} note_t;
	logic              clk       = 1'h0;
	logic              reset_n   = 1'h0;
	logic [ADDR_W-1:0] regAddr   = 24'h00_0000;
	logic [31:0]       regWdata  = WORD_ZERO;
	logic              regWrite  = 1'h0;
	logic              regRead   = 1'h0;
	logic [31:0]       regRdata;
	logic              frameDone = 1'h0;
	logic              coprocReset;
	logic              rdSeen    = 1'h0;
	logic              cpExp     = 1'h0;
	logic [31:0]       lastData  = WORD_ZERO;
	logic [31:0]       hzVal;
	note_t             notes[$];
	note_t             cur;
	int                errors    = 0;
	int                compares  = 0;
	int                frames;

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	system_control_status_regs #(.CHIP_ID(TEST_ID)) u_dut (.clk(clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .frameDone(frameDone), .coprocReset(coprocReset));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Strobes are set explicitly each cycle so back-to-back accesses never clash.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		regRead <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] k);
		notes.push_back('{e, cpExp, k});
		regAddr <= a;
		regWrite <= 1'h0;
		regRead <= 1'h1;
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		regWrite <= 1'h0;
		regRead <= 1'h0;
		repeat (n) @(posedge clk);
	endtask

	// Read data stand only in the cycle after the strobe; the old value is sampled here.
	always @(posedge clk) begin
		if (rdSeen && notes.size() > 0) begin
			cur = notes.pop_front();
			if (cur.kind == 2'h0) check(regRdata, cur.data);
			if (cur.kind == 2'h2) check(regRdata, lastData + cur.data);
			check({31'h0000_0000, coprocReset}, {31'h0000_0000, cur.rst});
			lastData = regRdata;
		end
		rdSeen = regRead;
	end

	// Main sequence: reset values, control bit, clock value, read-only places, frames.
	initial begin
		void'($urandom(95268));
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		rd(OFF_CHIP_ID, {24'h00_0000, TEST_ID}, 2'h0);
		rd(OFF_FRAME_CNT, WORD_ZERO, 2'h0);
		rd(OFF_MAIN_HZ, MAIN_HZ_RESET, 2'h0);
		rd(OFF_COPROC_RST, WORD_ZERO, 2'h0);
		rd(24'h10_2410, WORD_ZERO, 2'h0);
		wr(OFF_COPROC_RST, $urandom() | 32'h0000_0001);
		cpExp = 1'h1;
		rd(OFF_COPROC_RST, 32'h0000_0001, 2'h0);
		wr(OFF_COPROC_RST, $urandom() & 32'hFFFF_FFFE);
		cpExp = 1'h0;
		rd(OFF_COPROC_RST, WORD_ZERO, 2'h0);
		for (int i = 0; i < 2; i++) begin
			hzVal = (i == 0) ? 32'h0225_5100 : $urandom();
			wr(OFF_MAIN_HZ, hzVal);
			rd(OFF_MAIN_HZ, hzVal, 2'h0);
		end
		// Read-only places must ignore writes, the cycle counter keeps stepping.
		rd(OFF_CYCLE_CNT, WORD_ZERO, 2'h1);
		wr(OFF_CYCLE_CNT, $urandom());
		rd(OFF_CYCLE_CNT, 32'h0000_0002, 2'h2);
		rd(OFF_CYCLE_CNT, 32'h0000_0001, 2'h2);
		wr(OFF_CHIP_ID, $urandom());
		wr(OFF_FRAME_CNT, $urandom());
		rd(OFF_CHIP_ID, {24'h00_0000, TEST_ID}, 2'h0);
		frames = $urandom_range(2, 5);
		// Frame pulses last three cycles, above the two-cycle width that the synchroniser needs.
		repeat (frames) begin
			frameDone <= 1'h1;
			idle(3);
			frameDone <= 1'h0;
			idle(3);
		end
		idle(6);
		rd(OFF_FRAME_CNT, frames, 2'h0);
		wr(OFF_COPROC_RST, 32'h0000_0001);
		wr(OFF_MAIN_HZ, $urandom());
		idle(3);
		// A second reset mid-run must restore the reset control, the clock value and the frame count.
		reset_n <= 1'h0;
		idle(2);
		reset_n <= 1'h1;
		cpExp = 1'h0;
		idle(1);
		rd(OFF_COPROC_RST, WORD_ZERO, 2'h0);
		rd(OFF_MAIN_HZ, MAIN_HZ_RESET, 2'h0);
		rd(OFF_FRAME_CNT, WORD_ZERO, 2'h0);
		idle(3);
		summarize();
	end

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		#200000;
		errors++;
		summarize();
	end
endmodule
